// >>> hdl/nlec_regs.vh
// Register offsets, field positions and encodings of the nested leaf entry checker.
`ifndef NLEC_REGS_VH
`define NLEC_REGS_VH

// Register byte offsets on the APB bus.
`define NLEC_OFS_NTP      8'h00
`define NLEC_OFS_CFG      8'h04
`define NLEC_OFS_TBASE    8'h08
`define NLEC_OFS_STATUS   8'h0C
`define NLEC_OFS_PA_LO    8'h10
`define NLEC_OFS_PA_HI    8'h14
`define NLEC_OFS_ATTR     8'h18
`define NLEC_OFS_COUNT    8'h1C

// Reset values.
`define NLEC_RST_WORD     32'h00000000
`define NLEC_RST_CNT      16'h0000

// Leaf entry fields.
`define NLEC_BIT_READ     0
`define NLEC_BIT_WRITE    1
`define NLEC_BIT_EXEC     2
`define NLEC_PERM_HI      2
`define NLEC_PERM_LO      0
`define NLEC_MT_HI        5
`define NLEC_MT_LO        3
`define NLEC_BIT_IGN_PAT  6
`define NLEC_BIT_SIZE     7
`define NLEC_BIT_ACC      8
`define NLEC_BIT_DIRTY    9
`define NLEC_FRAME_LO     12
`define NLEC_RSVD_TOP     52
`define NLEC_GPA_HI       11

// Nested table pointer bit that enables accessed and dirty flags.
`define NLEC_NTP_AD_BIT   6

// Configuration register bits.
`define NLEC_CFG_XONLY    0

// Status register bits.
`define NLEC_ST_PASS      0
`define NLEC_ST_MISCFG    1
`define NLEC_ST_VIOL      2
`define NLEC_ST_DONE      3

// Attribute register fields.
`define NLEC_AT_MT_HI     2
`define NLEC_AT_IGN_PAT   3
`define NLEC_AT_ACC       4
`define NLEC_AT_DIRTY     5
`define NLEC_AT_PERM_HI   8
`define NLEC_AT_PERM_LO   6
`define NLEC_AT_KIND_HI   10
`define NLEC_AT_KIND_LO   9

// Permission patterns.
`define NLEC_PERM_NONE    3'h0
`define NLEC_PERM_WO      3'h2
`define NLEC_PERM_WX      3'h6
`define NLEC_PERM_XO      3'h4

// Reserved memory type encodings.
`define NLEC_MT_RSV_A     3'h2
`define NLEC_MT_RSV_B     3'h3
`define NLEC_MT_RSV_C     3'h7

// Entry kinds.
`define NLEC_KIND_ABSENT  2'h0
`define NLEC_KIND_PAGE    2'h1
`define NLEC_KIND_TABLE   2'h2

// Access types.
`define NLEC_ACC_READ     2'h0
`define NLEC_ACC_WRITE    2'h1
`define NLEC_ACC_FETCH    2'h2
`define NLEC_ACC_GUEST    2'h3

`endif

// >>> hdl/nlec_entry_decode.v
// Field decoder for one nested translation entry.
`timescale 1ns/1ps
`default_nettype none
`include "nlec_regs.vh"

module nlec_entry_decode #(
	parameter PA_WIDTH = 46
) (
	input  wire [63:0] entry,
	input  wire        is_pte,
	input  wire        ad_enable,
	output reg  [1:0]  kind,
	output wire [2:0]  perm,
	output wire [2:0]  mem_type,
	output wire        ignore_pat,
	output wire        accessed,
	output wire        dirty,
	output wire        rsvd_set,
	output wire [63:0] frame
);

	wire [63:0] rsvd_mask;
	wire [63:0] frame_mask;

	assign perm       = entry[`NLEC_PERM_HI:`NLEC_PERM_LO];
	assign mem_type   = entry[`NLEC_MT_HI:`NLEC_MT_LO];
	assign ignore_pat = entry[`NLEC_BIT_IGN_PAT];
	assign accessed   = ad_enable & entry[`NLEC_BIT_ACC];
	assign dirty      = ad_enable & entry[`NLEC_BIT_DIRTY];

	// Bits 63:52, 11:10 and bit 7 of a leaf never reach any mask below.
	assign rsvd_mask  = (64'h1 << `NLEC_RSVD_TOP) - (64'h1 << PA_WIDTH);
	assign frame_mask = (64'h1 << PA_WIDTH) - (64'h1 << `NLEC_FRAME_LO);
	assign rsvd_set   = |(entry & rsvd_mask);
	assign frame      = entry & frame_mask;

	always @* begin
		if (perm == `NLEC_PERM_NONE)
			kind = `NLEC_KIND_ABSENT;
		else if (is_pte || entry[`NLEC_BIT_SIZE])
			kind = `NLEC_KIND_PAGE;
		else
			kind = `NLEC_KIND_TABLE;
	end

endmodule
`default_nettype wire

// >>> hdl/nlec_leaf_check.v
// Nested leaf entry checker: classifies walked entries and holds results for APB reads.
//
// Overview of operation
// - Entry bit 0 grants data reads to the mapped page.
// - Entry bit 1 grants data writes to the mapped page.
// - Entry bit 2 grants instruction fetches from the mapped page.
// - Entry bits 5:3 give the memory type of the page.
// - Entry bit 6 tells memory typing to ignore the guest attribute table.
// - Bit 8 is the accessed flag only when pointer bit 6 is set.
// - Bit 9 is the dirty flag only when pointer bit 6 is set.
// - Bits from 12 to width minus one form the page frame address.
// - Bits from the physical width up to 51 are reserved, must be zero.
// - Bits 2:0 and bit 7 decide absent, page mapping or next table.
// - Any unsupported entry value raises a misconfiguration trap.
// - Violation only without misconfiguration and when permissions forbid the access.
// - Checks run only on a real guest-physical access attempt.
// - Writing the table base register never raises either trap.
// - Permission bits all zero mean absent; any access to it violates.
// - Final address keeps guest bits 11:0, upper bits 63:52 are zero.
// - Write-only or write-execute permission patterns are misconfigurations.
// - Reserved memory types 2, 3 and 7 in a present leaf misconfigure.
//
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "nlec_regs.vh"

module nlec_leaf_check #(
	parameter PA_WIDTH = 46
) (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	input  wire        chk_valid,
	input  wire [63:0] chk_entry,
	input  wire        chk_is_pte,
	input  wire [1:0]  chk_access,
	input  wire [11:0] chk_gpa_low,
	output reg         res_valid,
	output reg         res_pass,
	output reg         res_misconfig,
	output reg         res_violation,
	output reg  [1:0]  res_kind,
	output reg  [63:0] res_phys_addr,
	output reg  [2:0]  res_mem_type,
	output reg         res_ignore_pat,
	output reg         res_accessed,
	output reg         res_dirty
);

	// Software visible state.
	reg  [31:0] nested_table_pointer;
	reg  [31:0] cfg;
	reg  [31:0] table_base_control_reg;
	reg         st_done;
	reg  [15:0] miscfg_count;
	reg  [15:0] viol_count;

	// Decoder results.
	wire [1:0]  dec_kind;
	wire [2:0]  dec_perm;
	wire [2:0]  dec_mt;
	wire        dec_ign_pat;
	wire        dec_acc;
	wire        dec_dirty;
	wire        dec_rsvd;
	wire [63:0] dec_frame;

	// Classification.
	wire        ad_enable;
	wire        xonly_ok;
	wire        present;
	wire        bad_perm;
	wire        bad_mt;
	reg         next_misconfig;
	reg         next_violation;
	reg         treat_write;

	// Bus decode.
	wire        setup;
	wire        wr_en;
	reg         addr_ok;
	reg  [31:0] next_prdata;
	wire        clr_hit;

	assign ad_enable = nested_table_pointer[`NLEC_NTP_AD_BIT];
	assign xonly_ok  = cfg[`NLEC_CFG_XONLY];

	nlec_entry_decode #(
		.PA_WIDTH (PA_WIDTH)
	) u_decode (
		.entry      (chk_entry),
		.is_pte     (chk_is_pte),
		.ad_enable  (ad_enable),
		.kind       (dec_kind),
		.perm       (dec_perm),
		.mem_type   (dec_mt),
		.ignore_pat (dec_ign_pat),
		.accessed   (dec_acc),
		.dirty      (dec_dirty),
		.rsvd_set   (dec_rsvd),
		.frame      (dec_frame)
	);

	assign present  = (dec_kind != `NLEC_KIND_ABSENT);

	assign bad_perm = (dec_perm == `NLEC_PERM_WO) || (dec_perm == `NLEC_PERM_WX) ||
		((dec_perm == `NLEC_PERM_XO) && !xonly_ok);

	assign bad_mt   = (dec_kind == `NLEC_KIND_PAGE) && ((dec_mt == `NLEC_MT_RSV_A) ||
		(dec_mt == `NLEC_MT_RSV_B) || (dec_mt == `NLEC_MT_RSV_C));

	// Guest paging-structure accesses count as writes once accessed and dirty flags are on.
	always @* begin
		treat_write = (chk_access == `NLEC_ACC_WRITE) ||
			((chk_access == `NLEC_ACC_GUEST) && ad_enable);
	end

	always @* begin
		next_misconfig = present && (bad_perm || bad_mt || dec_rsvd);
		next_violation = 1'b0;
		if (!present) begin
			next_violation = 1'b1;
		end else if (!next_misconfig) begin
			case (chk_access)
				`NLEC_ACC_READ: begin
					next_violation = !dec_perm[`NLEC_BIT_READ];
				end
				`NLEC_ACC_WRITE: begin
					next_violation = !dec_perm[`NLEC_BIT_WRITE];
				end
				`NLEC_ACC_FETCH: begin
					next_violation = !dec_perm[`NLEC_BIT_EXEC];
				end
				`NLEC_ACC_GUEST: begin
					next_violation = treat_write ? !dec_perm[`NLEC_BIT_WRITE] :
						!dec_perm[`NLEC_BIT_READ];
				end
				default: begin
					next_violation = 1'b1;
				end
			endcase
		end
	end

	// Result registers other than res_valid update only when a walk presents an entry for a real access; res_valid follows chk_valid every cycle.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			res_valid      <= 1'b0;
			res_pass       <= 1'b0;
			res_misconfig  <= 1'b0;
			res_violation  <= 1'b0;
			res_kind       <= `NLEC_KIND_ABSENT;
			res_phys_addr  <= 64'h0000000000000000;
			res_mem_type   <= 3'h0;
			res_ignore_pat <= 1'b0;
			res_accessed   <= 1'b0;
			res_dirty      <= 1'b0;
		end else begin
			res_valid <= chk_valid;
			if (chk_valid) begin
				res_misconfig  <= next_misconfig;
				res_violation  <= next_violation;
				res_pass       <= !next_misconfig && !next_violation;
				res_kind       <= dec_kind;
				res_phys_addr  <= (dec_kind == `NLEC_KIND_PAGE) ?
					{dec_frame[63:`NLEC_GPA_HI+1], chk_gpa_low} : dec_frame;
				res_mem_type   <= dec_mt;
				res_ignore_pat <= dec_ign_pat;
				res_accessed   <= dec_acc;
				res_dirty      <= dec_dirty;
			end
		end
	end

	// APB slave: zero wait states, read data sampled in the setup cycle.
	assign setup   = psel && !penable;
	assign wr_en   = psel && penable && pwrite;
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !addr_ok;
	assign clr_hit = wr_en && (paddr == `NLEC_OFS_COUNT);

	always @* begin
		addr_ok     = 1'b1;
		next_prdata = `NLEC_RST_WORD;
		case (paddr)
			`NLEC_OFS_NTP: begin
				next_prdata = nested_table_pointer;
			end
			`NLEC_OFS_CFG: begin
				next_prdata = cfg;
			end
			`NLEC_OFS_TBASE: begin
				next_prdata = table_base_control_reg;
			end
			`NLEC_OFS_STATUS: begin
				next_prdata[`NLEC_ST_PASS]   = res_pass;
				next_prdata[`NLEC_ST_MISCFG] = res_misconfig;
				next_prdata[`NLEC_ST_VIOL]   = res_violation;
				next_prdata[`NLEC_ST_DONE]   = st_done;
			end
			`NLEC_OFS_PA_LO: begin
				next_prdata = res_phys_addr[31:0];
			end
			`NLEC_OFS_PA_HI: begin
				next_prdata = res_phys_addr[63:32];
			end
			`NLEC_OFS_ATTR: begin
				next_prdata[`NLEC_AT_MT_HI:0]                 = res_mem_type;
				next_prdata[`NLEC_AT_IGN_PAT]                 = res_ignore_pat;
				next_prdata[`NLEC_AT_ACC]                     = res_accessed;
				next_prdata[`NLEC_AT_DIRTY]                   = res_dirty;
				next_prdata[`NLEC_AT_PERM_HI:`NLEC_AT_PERM_LO] = res_pass ?
					3'h0 : 3'h0;
				next_prdata[`NLEC_AT_KIND_HI:`NLEC_AT_KIND_LO] = res_kind;
			end
			`NLEC_OFS_COUNT: begin
				next_prdata = {viol_count, miscfg_count};
			end
			default: begin
				addr_ok = 1'b0;
			end
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= `NLEC_RST_WORD;
		end else if (setup && !pwrite) begin
			prdata <= next_prdata;
		end
	end

	// Writing the table base only stores it; no check is started from here.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nested_table_pointer   <= `NLEC_RST_WORD;
			cfg                    <= `NLEC_RST_WORD;
			table_base_control_reg <= `NLEC_RST_WORD;
		end else if (wr_en) begin
			if (paddr == `NLEC_OFS_NTP)
				nested_table_pointer <= pwdata;
			if (paddr == `NLEC_OFS_CFG)
				cfg <= pwdata;
			if (paddr == `NLEC_OFS_TBASE)
				table_base_control_reg <= pwdata;
		end
	end

	// Done flag and counters: a check landing in the clearing cycle is still counted.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_done      <= 1'b0;
			miscfg_count <= `NLEC_RST_CNT;
			viol_count   <= `NLEC_RST_CNT;
		end else begin
			if (chk_valid)
				st_done <= 1'b1;
			else if (wr_en && (paddr == `NLEC_OFS_STATUS) && pwdata[`NLEC_ST_DONE])
				st_done <= 1'b0;
			if (clr_hit)
				miscfg_count <= {15'h0000, chk_valid && next_misconfig};
			else if (chk_valid && next_misconfig)
				miscfg_count <= miscfg_count + 16'h0001;
			if (clr_hit)
				viol_count <= {15'h0000, chk_valid && !next_misconfig && next_violation};
			else if (chk_valid && !next_misconfig && next_violation)
				viol_count <= viol_count + 16'h0001;
		end
	end

endmodule
`default_nettype wire

// >>> verification/nlec_leaf_check_properties.sv
// Concurrent checks on the ports of the nested leaf entry checker.
`timescale 1ns/1ps
`default_nettype none
module nlec_leaf_check_properties #(
	parameter PA_WIDTH = 46
) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [7:0]  paddr,
	input wire logic        pslverr,
	input wire logic        chk_valid,
	input wire logic [63:0] chk_entry,
	input wire logic        chk_is_pte,
	input wire logic [1:0]  chk_access,
	input wire logic [11:0] chk_gpa_low,
	input wire logic        res_valid,
	input wire logic        res_pass,
	input wire logic        res_misconfig,
	input wire logic        res_violation,
	input wire logic [63:0] res_phys_addr
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire [2:0] pm    = chk_entry[2:0];
	wire [2:0] mt    = chk_entry[5:3];
	wire       rsv   = |(chk_entry[51:0] >> PA_WIDTH);
	wire       mtbad = mt == 3'h2 || mt == 3'h3 || mt == 3'h7;
	// A present leaf with clean reserved bits; only type and rights decide.
	sequence leaf_in;
		chk_valid && chk_is_pte && pm != 3'h0 && !rsv;
	endsequence
	resp_next_a: assert property (chk_valid |=> res_valid)
		else $error("no result one cycle after a check");
	idle_quiet_a: assert property (!chk_valid |=> !res_valid)
		else $error("result without a check");
	one_outcome_a: assert property (res_valid |-> $onehot({res_pass, res_misconfig, res_violation}))
		else $error("outcome not unique");
	absent_viol_a: assert property (chk_valid && pm == 3'h0 |=> res_violation)
		else $error("absent entry did not violate");
	bad_perm_a: assert property (chk_valid && (pm == 3'h2 || pm == 3'h6) |=> res_misconfig)
		else $error("write without read not misconfigured");
	rsvd_bits_a: assert property (chk_valid && pm != 3'h0 && rsv |=> res_misconfig)
		else $error("reserved address bit accepted");
	bad_type_a: assert property (leaf_in ##0 mtbad |=> res_misconfig)
		else $error("reserved memory type accepted");
	write_deny_a: assert property (leaf_in ##0 (!mtbad && pm == 3'h1 && chk_access == 2'h1)
		|=> res_violation)
		else $error("write to read-only page allowed");
	read_pass_a: assert property (leaf_in ##0 (!mtbad && pm[0] && chk_access == 2'h0)
		|=> res_pass)
		else $error("permitted read refused");
	addr_form_a: assert property (res_valid && res_pass && $past(chk_is_pte) |-> res_phys_addr[11:0] ==
		$past(chk_gpa_low) && res_phys_addr[63:52] == 12'h000)
		else $error("page offset or top bits wrong");
	apb_err_a: assert property (psel && penable && paddr > 8'h1C |-> pslverr)
		else $error("unmapped access not refused");
endmodule
bind nlec_leaf_check nlec_leaf_check_properties #(.PA_WIDTH(PA_WIDTH)) u_props (
	.pclk, .presetn, .psel, .penable, .paddr, .pslverr, .chk_valid, .chk_entry,
	.chk_is_pte, .chk_access, .chk_gpa_low, .res_valid, .res_pass, .res_misconfig,
	.res_violation, .res_phys_addr
);
`default_nettype wire

// >>> verification/nlec_walk_model.sv
// Walk engine model that presents one translation entry per request.
`timescale 1ns/1ps
`default_nettype none
module nlec_walk_model (
	input  wire logic        pclk,
	output var  logic        chk_valid,
	output var  logic [63:0] chk_entry,
	output var  logic        chk_is_pte,
	output var  logic [1:0]  chk_access,
	output var  logic [11:0] chk_gpa_low
);
	initial begin
		chk_valid = 1'h0;
		chk_entry = 64'h0;
		chk_is_pte = 1'h0;
		chk_access = 2'h0;
		chk_gpa_low = 12'h0;
	end
	// Between pulses the lines carry inverted data, so a stale sample shows up.
	task present(input logic [63:0] e, input logic p, input logic [1:0] a, input logic [11:0] g);
		@(posedge pclk);
		chk_valid <= 1'h1;
		chk_entry <= e;
		chk_is_pte <= p;
		chk_access <= a;
		chk_gpa_low <= g;
		@(posedge pclk);
		chk_valid <= 1'h0;
		chk_entry <= ~e;
		chk_is_pte <= ~p;
		chk_access <= ~a;
		chk_gpa_low <= ~g;
	endtask
endmodule
`default_nettype wire

// >>> verification/testbench.sv
// Self-checking bench for the nested leaf entry checker.
`timescale 1ns/1ps
`default_nettype none
`include "nlec_regs.vh"
module testbench;
	localparam PAW = 46;
	localparam logic [2:0] P = 3'h4, M = 3'h2, V = 3'h1;
	localparam logic [63:0] E = 64'h0000_0012_3456_7000;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        chk_valid, chk_is_pte, res_valid, res_pass, res_misconfig, res_violation;
	logic        res_ignore_pat, res_accessed, res_dirty;
	logic [63:0] chk_entry, res_phys_addr;
	logic [1:0]  chk_access, res_kind;
	logic [11:0] chk_gpa_low;
	logic [2:0]  res_mem_type;
	int          num_errors, checks_done, n_mc, n_vi;
	nlec_leaf_check #(.PA_WIDTH(PAW)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .chk_valid, .chk_entry, .chk_is_pte,
		.chk_access, .chk_gpa_low, .res_valid, .res_pass, .res_misconfig, .res_violation,
		.res_kind, .res_phys_addr, .res_mem_type, .res_ignore_pat, .res_accessed, .res_dirty);
	nlec_walk_model i_walk (.pclk, .chk_valid, .chk_entry, .chk_is_pte, .chk_access,
		.chk_gpa_low);
	initial begin
		pclk = 1'h0;
		forever #5 pclk = ~pclk;
	end
	task check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'h1 && n < 50);
		// A transfer that never completes counts against the run.
		if (pready !== 1'h1)
			num_errors++;
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	// Outcome is {pass, misconfig, violation}; the offset is fixed at A5C.
	task run(input logic [63:0] e, input logic [1:0] a, input logic [2:0] exp);
		int n;
		i_walk.present(e, 1'h1, a, 12'hA5C);
		n = 0;
		while (res_valid !== 1'h1 && n < 4) begin
			@(negedge pclk);
			n++;
		end
		check("res_valid", res_valid, 1'h1);
		check("outcome", {res_pass, res_misconfig, res_violation}, exp);
		if (exp == P)
			check("phys", res_phys_addr, {12'h000, e[51:12], 12'hA5C});
		n_mc += exp[1];
		n_vi += exp[0];
	endtask
	task print_verdict;
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#50000;
		num_errors++;
		print_verdict();
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{num_errors, checks_done, n_mc, n_vi} = '0;
		repeat (12) @(posedge pclk);
		presetn <= 1'h1;
		apb(1'h0, `NLEC_OFS_STATUS, 32'h0);
		check("status reset", rd, 32'h0);
		apb(1'h0, 8'h40, 32'h0);
		check("unmapped", err, 1'h1);
		apb(1'h1, `NLEC_OFS_NTP, 32'h40);
		apb(1'h1, `NLEC_OFS_TBASE, 32'h1234_5000);
		check("no trap", res_valid, 1'h0);
		apb(1'h0, `NLEC_OFS_STATUS, 32'h0);
		check("status quiet", rd, 32'h0);
		$display("test registers done");
		run(E | 64'h377, 2'h0, P);
		check("mtype", res_mem_type, 3'h6);
		check("ignpat", res_ignore_pat, 1'h1);
		check("acc", res_accessed, 1'h1);
		check("dirty", res_dirty, 1'h1);
		check("kind", res_kind, `NLEC_KIND_PAGE);
		apb(1'h0, `NLEC_OFS_ATTR, 32'h0);
		check("attr", rd, 32'h0000023E);
		apb(1'h0, `NLEC_OFS_PA_HI, 32'h0);
		check("pa hi", rd, 32'h00000012);
		apb(1'h0, `NLEC_OFS_STATUS, 32'h0);
		check("status done", rd, 32'h00000009);
		apb(1'h1, `NLEC_OFS_STATUS, 32'h00000008);
		apb(1'h0, `NLEC_OFS_STATUS, 32'h0);
		check("status clear", rd, 32'h00000001);
		run(64'hFFF0_0012_3456_7FF7, 2'h0, P);
		run(64'hFFFF_FFFF_FFFF_FFF8, 2'h1, V);
		check("kind", res_kind, `NLEC_KIND_ABSENT);
		run(E | 64'h32, 2'h1, M);
		run(E | 64'h36, 2'h2, M);
		run(E | 64'h31, 2'h0, P);
		run(E | 64'h31, 2'h1, V);
		run(E | 64'h31, 2'h2, V);
		run(E | 64'h33, 2'h1, P);
		run(E | 64'h35, 2'h2, P);
		run(E | 64'h11, 2'h1, M);
		run(E | 64'h31, 2'h3, V);
		$display("test permissions done");
		for (int i = 0; i < 8; i++) begin
			run(E | (64'(i) << 3) | 64'h7, 2'h0, (i == 2 || i == 3 || i == 7) ? M : P);
			check("mtype", res_mem_type, i[2:0]);
		end
		run(E | (64'h1 << PAW) | 64'h7, 2'h0, M);
		run(E | 64'h0008_0000_0000_0007, 2'h0, M);
		run(E | (64'h1 << (PAW - 1)) | 64'h7, 2'h0, P);
		run(E | 64'h34, 2'h2, M);
		apb(1'h1, `NLEC_OFS_CFG, 32'h1);
		run(E | 64'h34, 2'h2, P);
		run(E | 64'h34, 2'h0, V);
		$display("test types done");
		apb(1'h0, `NLEC_OFS_COUNT, 32'h0);
		check("count", rd, {n_vi[15:0], n_mc[15:0]});
		apb(1'h1, `NLEC_OFS_NTP, 32'h0);
		run(E | 64'h377, 2'h0, P);
		check("acc off", res_accessed, 1'h0);
		check("dirty off", res_dirty, 1'h0);
		run(E | 64'h31, 2'h3, P);
		i_walk.present(E | 64'h7, 1'h0, 2'h0, 12'h0);
		@(negedge pclk);
		check("kind", res_kind, `NLEC_KIND_TABLE);
		$display("test flags done");
		print_verdict();
	end
endmodule
`default_nettype wire
